// ==== hw/sopm_pkg.sv ====
package sopm_pkg;
   localparam logic [3:0]  RK_READ        = 4'h1;
   localparam logic [3:0]  RK_WRITE       = 4'h2;
   localparam logic [15:0] PNU_STATUS     = 16'h0003;
   localparam logic [7:0]  SUB_HOURS      = 8'h0a;
   localparam logic [7:0]  SUB_COUNT      = 8'h0b;
   localparam logic [7:0]  SUB_CYCLE      = 8'h0c;
   localparam logic [7:0]  SUB_REV        = 8'h0d;
   localparam logic [7:0]  SUB_LOCATOR    = 8'h0e;
   localparam logic [7:0]  SUB_AMP        = 8'h0f;
   localparam logic [15:0] PNU_NODE       = 16'h0396;
   localparam logic [15:0] PNU_ALARM      = 16'h03b3;
   localparam logic [7:0]  ALARM_SUB_LAST = 8'h30;
   localparam int          ALARM_ENTRIES  = 6;
   localparam logic [15:0] PNU_LIST_FIRST = 16'h03d4;
   localparam logic [15:0] PNU_LIST_LAST  = 16'h03dd;
   localparam logic [7:0]  LIST_PER_PNU   = 8'h74;
   localparam logic [15:0] COMMON_FIRST   = 16'h03e8;
   localparam logic [15:0] COMMON_LAST    = 16'h0423;
   localparam logic [15:0] POS_FIRST      = 16'h04b0;
   localparam logic [15:0] POS_LAST       = 16'h04ff;
   localparam logic [15:0] SERVO_FIRST    = 16'h0579;
   localparam logic [15:0] SERVO_LAST     = 16'h059f;
   localparam logic [7:0]  MEM_POS_BASE   = 8'h3c;
   localparam logic [7:0]  MEM_SERVO_BASE = 8'h8c;
   localparam logic [7:0]  SUB_VALUE      = 8'h01;
   localparam logic [7:0]  SUB_DESC       = 8'h02;
   localparam logic [15:0] AMP_NONE       = 16'h0000;
   localparam logic [15:0] AMP_FAMILY     = 16'h0001;
   localparam logic [15:0] LOCATOR_SUB    = 16'h0001;
   localparam logic [15:0] ERR_NONE       = 16'h0000;
   localparam logic [15:0] ERR_PNU        = 16'h0001;
   localparam logic [15:0] ERR_READ_ONLY  = 16'h0002;
   localparam logic [15:0] ERR_SUB        = 16'h0003;
   localparam logic [15:0] ERR_KIND       = 16'h0004;
   localparam int          DESC_POINT_LSB = 0;
   localparam int          DESC_REP_LSB   = 4;
   localparam int          DESC_EFF_LSB   = 8;

   typedef enum logic [1:0] {
      GRP_NONE   = 2'b00,
      GRP_COMMON = 2'b01,
      GRP_POS    = 2'b10,
      GRP_SERVO  = 2'b11
   } sopm_grp_t;

   // Builds a descriptor word with each field in its own nibble.
   function automatic logic [15:0] make_desc(input logic [2:0] point,
                                             input logic       rep,
                                             input logic       eff);
      logic [15:0] d;
      d = 16'h0000;
      d[DESC_POINT_LSB +: 3] = point;
      d[DESC_REP_LSB]        = rep;
      d[DESC_EFF_LSB]        = eff;
      return d;
   endfunction : make_desc
endpackage : sopm_pkg

// ==== hw/sopm_mem_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port of the setting value memory.
interface sopm_mem_if #(parameter int AW = 8, parameter int DW = 16);
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface : sopm_mem_if
`default_nettype wire

// ==== hw/sopm_param_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
// Single-port memory of setting values with registered read data.
module sopm_param_mem #(
   parameter int AW    = 8,
   parameter int DW    = 16,
   parameter int DEPTH = 256
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   sopm_mem_if.mem  port
);
   logic [DW-1:0] store [DEPTH];
   logic [DW-1:0] rdata_r;

   // Writes the addressed word when enabled.
   always_ff @(posedge mclk_in) begin
      if (port.we) begin
         store[port.addr] <= port.wdata;
      end
   end

   // Registers the read word; a write reads back the new value.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_r <= '0;
      end else if (port.we) begin
         rdata_r <= port.wdata;
      end else begin
         rdata_r <= store[port.addr];
      end
   end

   assign port.rdata = rdata_r;
endmodule : sopm_param_mem
`default_nettype wire

// ==== hw/sopm_param_map.sv ====
`timescale 1ns/10ps
`default_nettype none
// Parameter map answering the parameter channel.
module sopm_param_map #(
   parameter logic [15:0] DESC_COMMON = sopm_pkg::make_desc(3'h0, 1'b1, 1'b0),
   parameter logic [15:0] DESC_POS    = sopm_pkg::make_desc(3'h0, 1'b1, 1'b0),
   parameter logic [15:0] DESC_SERVO  = sopm_pkg::make_desc(3'h0, 1'b1, 1'b1)
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic [3:0]  request_kind_in,
   input  wire logic [15:0] parameter_number_in,
   input  wire logic [7:0]  sub_index_select_in,
   input  wire logic [31:0] parameter_value_field_in,
   input  wire logic        task_request_flag_in,
   input  wire logic [15:0] power_on_hours_in,
   input  wire logic [15:0] power_on_count_in,
   input  wire logic [31:0] home_cycle_in,
   input  wire logic [15:0] home_revolution_in,
   input  wire logic        amplifier_connected_in,
   input  wire logic [15:0] node_address_in,
   input  wire logic        alarm_event_in,
   input  wire logic [15:0] alarm_number_in,
   output logic [31:0]      parameter_value_field_out,
   output logic [15:0]      second_value_word_out,
   output logic             task_done_out,
   output logic             task_error_out
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_DONE  = 2'b10
   } sopm_state_t;

   sopm_state_t       st_r;
   sopm_state_t       st_nxt;
   sopm_pkg::sopm_grp_t grp_r;
   sopm_pkg::sopm_grp_t grp_live;
   logic [3:0]        kind_r;
   logic [15:0]       pnu_r;
   logic [7:0]        sub_r;
   logic [15:0]       wval_r;
   logic [31:0]       value_r;
   logic [31:0]       val_nxt;
   logic [15:0]       err_r;
   logic [15:0]       err_nxt;
   logic              err_flag_r;
   logic [31:0]       locator_r;
   logic [15:0]       alarm_r [sopm_pkg::ALARM_ENTRIES];
   logic              accept;
   logic [7:0]        mem_idx;
   logic [7:0]        alarm_pos;
   logic [10:0]       list_idx;

   sopm_mem_if #(.AW(8), .DW(16)) mem_port ();

   sopm_param_mem #(.AW(8), .DW(16), .DEPTH(256)) u_mem (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .port    (mem_port)
   );

   // Classifies a number into a setting group.
   function automatic sopm_pkg::sopm_grp_t group_of(input logic [15:0] parameter_number);
      if (parameter_number >= sopm_pkg::COMMON_FIRST && parameter_number <= sopm_pkg::COMMON_LAST) begin
         return sopm_pkg::GRP_COMMON;
      end else if (parameter_number >= sopm_pkg::POS_FIRST && parameter_number <= sopm_pkg::POS_LAST) begin
         return sopm_pkg::GRP_POS;
      end else if (parameter_number >= sopm_pkg::SERVO_FIRST && parameter_number <= sopm_pkg::SERVO_LAST) begin
         return sopm_pkg::GRP_SERVO;
      end
      return sopm_pkg::GRP_NONE;
   endfunction : group_of

   // Returns the n-th supported number in ascending order, zero past the end.
   function automatic logic [15:0] list_entry(input logic [10:0] i);
      logic [15:0] w;
      w = {5'h00, i};
      if (w == 16'h0000) begin
         return sopm_pkg::PNU_STATUS;
      end else if (w == 16'h0001) begin
         return sopm_pkg::PNU_NODE;
      end else if (w == 16'h0002) begin
         return sopm_pkg::PNU_ALARM;
      end else if (w < 16'h000d) begin
         return 16'(sopm_pkg::PNU_LIST_FIRST + w - 16'h0003);
      end else if (w < 16'h0049) begin
         return 16'(sopm_pkg::COMMON_FIRST + w - 16'h000d);
      end else if (w < 16'h0099) begin
         return 16'(sopm_pkg::POS_FIRST + w - 16'h0049);
      end else if (w < 16'h00c0) begin
         return 16'(sopm_pkg::SERVO_FIRST + w - 16'h0099);
      end
      return 16'h0000;
   endfunction : list_entry

   assign accept   = (st_r == ST_IDLE) && task_request_flag_in;
   assign grp_live = group_of(parameter_number_in);

   // Maps the live number onto a flat memory index.
   always_comb begin
      mem_idx = 8'h00;
      unique case (grp_live)
         sopm_pkg::GRP_COMMON: mem_idx = 8'(parameter_number_in - sopm_pkg::COMMON_FIRST);
         sopm_pkg::GRP_POS:    mem_idx = 8'(parameter_number_in - sopm_pkg::POS_FIRST
                                            + 16'(sopm_pkg::MEM_POS_BASE));
         sopm_pkg::GRP_SERVO:  mem_idx = 8'(parameter_number_in - sopm_pkg::SERVO_FIRST
                                            + 16'(sopm_pkg::MEM_SERVO_BASE));
         sopm_pkg::GRP_NONE:   mem_idx = 8'h00;
      endcase
   end

   // Drives the memory; a value write is stored on the accepting edge.
   assign mem_port.addr  = mem_idx;
   assign mem_port.wdata = parameter_value_field_in[15:0];
   assign mem_port.we    = accept && request_kind_in == sopm_pkg::RK_WRITE
                           && grp_live != sopm_pkg::GRP_NONE
                           && sub_index_select_in == sopm_pkg::SUB_VALUE;

   // Captures the request fields when a task is accepted.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         kind_r <= 4'h0;
         pnu_r  <= 16'h0000;
         sub_r  <= 8'h00;
         wval_r <= 16'h0000;
         grp_r  <= sopm_pkg::GRP_NONE;
      end else if (accept) begin
         kind_r <= request_kind_in;
         pnu_r  <= parameter_number_in;
         sub_r  <= sub_index_select_in;
         wval_r <= parameter_value_field_in[15:0];
         grp_r  <= grp_live;
      end
   end

   assign alarm_pos = 8'(sub_r - 8'h01);
   assign list_idx  = 11'(16'(pnu_r - sopm_pkg::PNU_LIST_FIRST) * 16'(sopm_pkg::LIST_PER_PNU)
                          + 16'(sub_r) - 16'h0001);

   // Works out the answer or the error for the captured request.
   always_comb begin
      val_nxt = 32'h0000_0000;
      err_nxt = sopm_pkg::ERR_NONE;
      if (kind_r != sopm_pkg::RK_READ && kind_r != sopm_pkg::RK_WRITE) begin
         err_nxt = sopm_pkg::ERR_KIND;
      end else if (pnu_r == sopm_pkg::PNU_STATUS) begin
         if (kind_r == sopm_pkg::RK_WRITE) begin
            err_nxt = sopm_pkg::ERR_READ_ONLY;
         end else if (sub_r == sopm_pkg::SUB_HOURS) begin
            val_nxt = {16'h0000, power_on_hours_in};
         end else if (sub_r == sopm_pkg::SUB_COUNT) begin
            val_nxt = {16'h0000, power_on_count_in};
         end else if (sub_r == sopm_pkg::SUB_CYCLE) begin
            val_nxt = home_cycle_in;
         end else if (sub_r == sopm_pkg::SUB_REV) begin
            val_nxt = {16'h0000, home_revolution_in};
         end else if (sub_r == sopm_pkg::SUB_LOCATOR) begin
            val_nxt = locator_r;
         end else if (sub_r == sopm_pkg::SUB_AMP) begin
            val_nxt = {16'h0000, amplifier_connected_in ? sopm_pkg::AMP_FAMILY
                                                        : sopm_pkg::AMP_NONE};
         end else begin
            err_nxt = sopm_pkg::ERR_SUB;
         end
      end else if (pnu_r == sopm_pkg::PNU_NODE) begin
         if (kind_r == sopm_pkg::RK_WRITE) begin
            err_nxt = sopm_pkg::ERR_READ_ONLY;
         end else begin
            val_nxt = {16'h0000, node_address_in};
         end
      end else if (pnu_r == sopm_pkg::PNU_ALARM) begin
         if (kind_r == sopm_pkg::RK_WRITE) begin
            err_nxt = sopm_pkg::ERR_READ_ONLY;
         end else if (sub_r == 8'h00 || sub_r > sopm_pkg::ALARM_SUB_LAST) begin
            err_nxt = sopm_pkg::ERR_SUB;
         end else if (alarm_pos[2:0] == 3'h0) begin
            val_nxt = {16'h0000, alarm_r[alarm_pos[5:3]]};
         end
      end else if (pnu_r >= sopm_pkg::PNU_LIST_FIRST && pnu_r <= sopm_pkg::PNU_LIST_LAST) begin
         if (kind_r == sopm_pkg::RK_WRITE) begin
            err_nxt = sopm_pkg::ERR_READ_ONLY;
         end else if (sub_r == 8'h00 || sub_r > sopm_pkg::LIST_PER_PNU) begin
            err_nxt = sopm_pkg::ERR_SUB;
         end else begin
            val_nxt = {16'h0000, list_entry(list_idx)};
         end
      end else if (grp_r != sopm_pkg::GRP_NONE) begin
         if (sub_r == sopm_pkg::SUB_VALUE) begin
            val_nxt = {16'h0000, mem_port.rdata};
         end else if (sub_r != sopm_pkg::SUB_DESC) begin
            err_nxt = sopm_pkg::ERR_SUB;
         end else if (kind_r == sopm_pkg::RK_WRITE) begin
            err_nxt = sopm_pkg::ERR_READ_ONLY;
         end else if (grp_r == sopm_pkg::GRP_COMMON) begin
            val_nxt = {16'h0000, DESC_COMMON};
         end else if (grp_r == sopm_pkg::GRP_POS) begin
            val_nxt = {16'h0000, DESC_POS};
         end else begin
            val_nxt = {16'h0000, DESC_SERVO};
         end
      end else begin
         err_nxt = sopm_pkg::ERR_PNU;
      end
   end

   // Steps the task handshake: accept, look up, hold completion.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE:  st_nxt = task_request_flag_in ? ST_FETCH : ST_IDLE;
         ST_FETCH: st_nxt = ST_DONE;
         ST_DONE:  st_nxt = task_request_flag_in ? ST_DONE : ST_IDLE;
         default:  st_nxt = ST_IDLE;
      endcase
   end

   // Holds the handshake state.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Loads the answer words at the end of the look-up.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         value_r    <= 32'h0000_0000;
         err_r      <= sopm_pkg::ERR_NONE;
         err_flag_r <= 1'b0;
      end else if (st_r == ST_FETCH) begin
         value_r    <= (kind_r == sopm_pkg::RK_WRITE && err_nxt == sopm_pkg::ERR_NONE)
                       ? {16'h0000, wval_r} : val_nxt;
         err_r      <= err_nxt;
         err_flag_r <= err_nxt != sopm_pkg::ERR_NONE;
      end
   end

   // Records which entry last failed; the sub-index half is fixed.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         locator_r <= {16'h0000, sopm_pkg::LOCATOR_SUB};
      end else if (st_r == ST_FETCH && err_nxt != sopm_pkg::ERR_NONE) begin
         locator_r <= {pnu_r, sopm_pkg::LOCATOR_SUB};
      end
   end

   // Pushes a new alarm number into the six-deep history.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         for (int k = 0; k < sopm_pkg::ALARM_ENTRIES; k++) begin
            alarm_r[k] <= 16'h0000;
         end
      end else if (alarm_event_in) begin
         alarm_r[0] <= alarm_number_in;
         for (int k = 1; k < sopm_pkg::ALARM_ENTRIES; k++) begin
            alarm_r[k] <= alarm_r[k-1];
         end
      end
   end

   assign parameter_value_field_out = value_r;
   assign second_value_word_out     = err_r;
   assign task_done_out             = (st_r == ST_DONE);
   assign task_error_out            = err_flag_r;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   a_done_after_accept: assert property (accept |-> ##2 task_done_out)
      else $error("completion not two cycles after accept");
   a_done_held_request: assert property (task_done_out && task_request_flag_in |=> task_done_out)
      else $error("completion dropped while request held");
   a_done_release: assert property (task_done_out && !task_request_flag_in |=> !task_done_out)
      else $error("completion kept after request dropped");
   a_write_stores_value: assert property (accept && request_kind_in == sopm_pkg::RK_WRITE
      && grp_live == sopm_pkg::GRP_COMMON && sub_index_select_in == sopm_pkg::SUB_VALUE
      |-> mem_port.we ##1 mem_port.rdata == $past(parameter_value_field_in[15:0]))
      else $error("write value not stored");
   a_error_code_word: assert property (task_error_out |-> second_value_word_out != sopm_pkg::ERR_NONE)
      else $error("error flag without code");
   a_desc_read_only: assert property (accept && request_kind_in == sopm_pkg::RK_WRITE
      && grp_live != sopm_pkg::GRP_NONE && sub_index_select_in == sopm_pkg::SUB_DESC
      |-> ##2 task_error_out && second_value_word_out == sopm_pkg::ERR_READ_ONLY)
      else $error("descriptor write not refused");
   a_locator_capture: assert property (st_r == ST_FETCH && err_nxt != sopm_pkg::ERR_NONE
      |=> locator_r == {$past(pnu_r), sopm_pkg::LOCATOR_SUB})
      else $error("error locator not captured");
   a_alarm_pad_zero: assert property (st_r == ST_FETCH && kind_r == sopm_pkg::RK_READ
      && pnu_r == sopm_pkg::PNU_ALARM && sub_r > 8'h01 && sub_r <= sopm_pkg::ALARM_SUB_LAST
      && alarm_pos[2:0] != 3'h0 |=> parameter_value_field_out == 32'h0000_0000)
      else $error("alarm pad sub-index not zero");
   a_alarm_shift: assert property (alarm_event_in |=> alarm_r[0] == $past(alarm_number_in)
      && alarm_r[1] == $past(alarm_r[0]))
      else $error("alarm history not shifted");
   a_amp_kind: assert property (st_r == ST_FETCH && kind_r == sopm_pkg::RK_READ
      && pnu_r == sopm_pkg::PNU_STATUS && sub_r == sopm_pkg::SUB_AMP
      |=> parameter_value_field_out == {31'h0, $past(amplifier_connected_in)})
      else $error("amplifier kind wrong");
endmodule : sopm_param_map
`default_nettype wire

// ==== dv/sopm_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// Master side of the parameter channel; it runs one task at a time.
module sopm_master (
   input  wire logic        mclk_in,
   input  wire logic [31:0] value_in,
   input  wire logic [15:0] code_in,
   input  wire logic        done_in,
   input  wire logic        error_in,
   output var logic [3:0]   kind_out,
   output var logic [15:0]  number_out,
   output var logic [7:0]   sub_out,
   output var logic [31:0]  data_out,
   output var logic         request_out
);
   int proto_errs = 0;

   // All lines start quiet so the device sees no request at time zero.
   initial begin
      kind_out    = 4'h0;
      number_out  = 16'h0000;
      sub_out     = 8'h00;
      data_out    = 32'h0000_0000;
      request_out = 1'b0;
   end

   // One task; the request stays up for hold extra cycles after completion.
   task automatic xfer(input logic [3:0] kind, input logic [15:0] num, input logic [7:0] sub,
                       input logic [31:0] data, input int hold, output logic [31:0] val,
                       output logic [15:0] code, output logic err);
      int n;
      @(negedge mclk_in);
      kind_out    = kind;
      number_out  = num;
      sub_out     = sub;
      data_out    = data;
      request_out = 1'b1;
      n = 0;
      @(negedge mclk_in);
      if (done_in !== 1'b0) proto_errs++;
      while (done_in !== 1'b1 && n < 8) begin
         @(negedge mclk_in);
         n++;
      end
      if (n == 8) proto_errs++;
      val  = value_in;
      code = code_in;
      err  = error_in;
      // Completion and answer must stand while the request is held.
      repeat (hold) begin
         @(negedge mclk_in);
         if (done_in !== 1'b1 || value_in !== val) proto_errs++;
      end
      // Released lines show the inverse so stale values are never mistaken for live ones.
      request_out = 1'b0;
      kind_out    = ~kind;
      number_out  = ~num;
      sub_out     = ~sub;
      data_out    = ~data;
      @(negedge mclk_in);
      if (done_in !== 1'b0) proto_errs++;
   endtask : xfer
endmodule : sopm_master
`default_nettype wire

// ==== dv/sopm_param_map_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module sopm_param_map_tb;
   logic        mclk_in = 1'b0;
   logic        rst_in  = 1'b1;
   logic [3:0]  kind;
   logic [15:0] num;
   logic [7:0]  sub;
   logic [31:0] wdata;
   logic        req;
   logic [15:0] hours   = 16'h1234;
   logic [15:0] count   = 16'h0042;
   logic [31:0] cycle   = 32'hdead_beef;
   logic [15:0] revs    = 16'h0777;
   logic        amp     = 1'b1;
   logic [15:0] node    = 16'h0021;
   logic        alarm   = 1'b0;
   logic [15:0] alarm_n = 16'h0000;
   logic [31:0] value;
   logic [15:0] code;
   logic        done;
   logic        err;
   int          fails = 0;
   int          checks_done = 0;
   int          hold_n = 0;
   logic [7:0]  st_sub [4] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d};
   logic [31:0] st_exp [4] = '{32'h1234, 32'h0042, 32'hdead_beef, 32'h0777};
   logic [15:0] wn [6] = '{16'h03e8, 16'h0423, 16'h04b0, 16'h04ff, 16'h0579, 16'h059f};
   logic [15:0] ln [10] = '{16'h03d4, 16'h03d4, 16'h03d4, 16'h03d4, 16'h03d4, 16'h03d4,
                            16'h03d4, 16'h03d5, 16'h03d5, 16'h03d5};
   logic [7:0]  ls [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0e, 8'h49, 8'h4a, 8'h26, 8'h4c,
                            8'h4d};
   logic [15:0] le [10] = '{16'h0003, 16'h0396, 16'h03b3, 16'h03d4, 16'h03e8, 16'h0423,
                            16'h04b0, 16'h0579, 16'h059f, 16'h0000};

   // Free-running 10 MHz clock.
   always #50 mclk_in = ~mclk_in;

   sopm_param_map u_sopm_param_map (
      .mclk_in                   (mclk_in),
      .rst_in                    (rst_in),
      .request_kind_in           (kind),
      .parameter_number_in       (num),
      .sub_index_select_in       (sub),
      .parameter_value_field_in  (wdata),
      .task_request_flag_in      (req),
      .power_on_hours_in         (hours),
      .power_on_count_in         (count),
      .home_cycle_in             (cycle),
      .home_revolution_in        (revs),
      .amplifier_connected_in    (amp),
      .node_address_in           (node),
      .alarm_event_in            (alarm),
      .alarm_number_in           (alarm_n),
      .parameter_value_field_out (value),
      .second_value_word_out     (code),
      .task_done_out             (done),
      .task_error_out            (err)
   );

   sopm_master u_sopm_master (
      .mclk_in     (mclk_in),
      .value_in    (value),
      .code_in     (code),
      .done_in     (done),
      .error_in    (err),
      .kind_out    (kind),
      .number_out  (num),
      .sub_out     (sub),
      .data_out    (wdata),
      .request_out (req)
   );

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // A read that must succeed with the given answer.
   task automatic rd(input logic [15:0] n, input logic [7:0] s, input logic [31:0] exp);
      logic [31:0] v;
      logic [15:0] c;
      logic        e;
      u_sopm_master.xfer(sopm_pkg::RK_READ, n, s, 32'h0, hold_n, v, c, e);
      chk(v, exp);
      chk({e, 15'h0000, c}, 32'h0);
   endtask : rd

   // A write that must succeed and echo its low half.
   task automatic wr(input logic [15:0] n, input logic [7:0] s, input logic [15:0] d);
      logic [31:0] v;
      logic [15:0] c;
      logic        e;
      u_sopm_master.xfer(sopm_pkg::RK_WRITE, n, s, {16'h0, d}, 0, v, c, e);
      chk(v, {16'h0000, d});
      chk({e, 15'h0000, c}, 32'h0);
   endtask : wr

   // A task that must fail with the given code and a zero answer.
   task automatic bad(input logic [3:0] k, input logic [15:0] n, input logic [7:0] s,
                      input logic [15:0] exp_code);
      logic [31:0] v;
      logic [15:0] c;
      logic        e;
      u_sopm_master.xfer(k, n, s, 32'h0000_5a5a, 0, v, c, e);
      chk(v, 32'h0);
      chk({e, 15'h0000, c}, {1'b1, 15'h0000, exp_code});
   endtask : bad

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // Cuts a hang short well beyond the expected run of about two hundred cycles.
   initial begin
      #2_000_000;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end

   // Main sequence.
   initial begin
      repeat (2) @(negedge mclk_in);
      rst_in = 1'b0;
      chk(value, 32'h0);
      chk({code, 14'h0000, done, err}, 32'h0);
      rd(16'h0003, 8'h0e, 32'h0000_0001);
      for (int i = 0; i < 4; i++) rd(16'h0003, st_sub[i], st_exp[i]);
      rd(16'h0003, 8'h0f, 32'h0001);
      @(negedge mclk_in);
      amp = 1'b0;
      rd(16'h0003, 8'h0f, 32'h0000);
      rd(16'h0396, 8'h01, 32'h0021);
      for (int i = 0; i < 6; i++) wr(wn[i], 8'h01, 16'ha500 + 16'(i));
      for (int i = 0; i < 6; i++) rd(wn[i], 8'h01, 32'ha500 + 32'(i));
      rd(16'h03e8, 8'h02, 32'h0010);
      rd(16'h04ff, 8'h02, 32'h0010);
      rd(16'h0579, 8'h02, 32'h0110);
      bad(sopm_pkg::RK_WRITE, 16'h03e8, 8'h02, sopm_pkg::ERR_READ_ONLY);
      bad(sopm_pkg::RK_WRITE, 16'h0396, 8'h01, sopm_pkg::ERR_READ_ONLY);
      bad(sopm_pkg::RK_WRITE, 16'h0003, 8'h0a, sopm_pkg::ERR_READ_ONLY);
      bad(sopm_pkg::RK_READ, 16'h03e8, 8'h03, sopm_pkg::ERR_SUB);
      bad(4'h3, 16'h03e8, 8'h01, sopm_pkg::ERR_KIND);
      bad(sopm_pkg::RK_READ, 16'h04af, 8'h01, sopm_pkg::ERR_PNU);
      bad(sopm_pkg::RK_READ, 16'h0500, 8'h01, sopm_pkg::ERR_PNU);
      bad(sopm_pkg::RK_READ, 16'h0578, 8'h01, sopm_pkg::ERR_PNU);
      bad(sopm_pkg::RK_READ, 16'h05a0, 8'h01, sopm_pkg::ERR_PNU);
      bad(sopm_pkg::RK_READ, 16'h0424, 8'h01, sopm_pkg::ERR_PNU);
      rd(16'h0003, 8'h0e, 32'h0424_0001);
      hold_n = 3;
      rd(16'h03e8, 8'h01, 32'ha500);
      hold_n = 0;
      // Seven alarms push the oldest one out of the six-entry history.
      for (int i = 0; i < 7; i++) begin
         @(negedge mclk_in);
         alarm   = 1'b1;
         alarm_n = 16'h0011 + 16'(i);
         @(negedge mclk_in);
         alarm   = 1'b0;
      end
      rd(16'h03b3, 8'h01, 32'h0017);
      rd(16'h03b3, 8'h02, 32'h0000);
      rd(16'h03b3, 8'h09, 32'h0016);
      rd(16'h03b3, 8'h29, 32'h0012);
      rd(16'h03b3, 8'h30, 32'h0000);
      for (int i = 0; i < 10; i++) rd(ln[i], ls[i], {16'h0000, le[i]});
      chk(u_sopm_master.proto_errs, 32'h0);
      summarize();
   end
endmodule : sopm_param_map_tb
`default_nettype wire
